// ==== eeprom_consts.svh ====
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH
`define EE_DEV_TYPE 4'hA
`define EE_CLK_MHZ 25
`define EE_WRITE_TIME_US 5000
`define EE_WRITE_CYC (`EE_WRITE_TIME_US * `EE_CLK_MHZ)
`define EE_REG_CTRL 8'h00
`define EE_REG_STATUS 8'h04
`define EE_CTRL_EN_BIT 0
`define EE_CTRL_RESET 1'b1
`define EE_ST_BUSY_BIT 0
`define EE_ST_ACTIVE_BIT 1
`define EE_ST_ADDR_LSB 8
`endif

// ==== eeprom_pkg.sv ====
package eeprom_pkg;
   typedef enum logic [3:0] {
      S_IDLE, S_CMD, S_CMD_ACK, S_ADDR, S_ADDR_ACK,
      S_WDATA, S_WDATA_ACK, S_RDATA, S_RD_MACK, S_RD_NEXT
   } ee_state_t;

   typedef struct packed {
      ee_state_t st;
      logic [7:0] shift;
      logic [3:0] bitcnt;
      logic [7:0] cur_addr;
      logic is_read;
      logic wrote;
      logic pull;
      logic [23:0] busy_cnt;
      logic scl_prev;
      logic sda_prev;
      logic ctrl_en;
      logic wb_ack;
      logic [31:0] wb_dat;
      logic sense_o;
      logic sense_oe;
      logic line;
   } ee_regs_t;
endpackage

// ==== sync2.sv ====
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk_i, // System clock
   input wire logic rst_i, // Synchronous reset
   input wire logic [W-1:0] d_i, // Asynchronous inputs
   output logic [W-1:0] q_o // Synchronised outputs
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= '0;
         q_o <= '0;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule // sync2

// ==== byte_store.sv ====
`timescale 1ns/1ps
module byte_store #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input wire logic clk_i, // System clock
   input wire logic we_i, // Write strobe
   input wire logic [AW-1:0] waddr_i, // Write address
   input wire logic [DW-1:0] wdata_i, // Write data
   input wire logic [AW-1:0] raddr_i, // Read address
   output logic [DW-1:0] rdata_o // Registered read data
);
   logic [DW-1:0] mem [2**AW];

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule // byte_store

// ==== eeprom_twowire.sv ====
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "eeprom_consts.svh"
module eeprom_twowire
   import eeprom_pkg::*;
#(
   parameter int WRITE_CYC = `EE_WRITE_CYC,
   parameter int AW = 8
) (
   input wire logic clk_i, // 25 MHz clock
   input wire logic rst_i, // Sync reset, active high
   input wire logic data_drive_bit_i, // Port bit, high pulls data low
   input wire logic serial_clock_bit_i, // Port bit, serial clock
   input wire logic data_sense_bit_i, // Sense pin, board drive value
   input wire logic data_sense_dir_i, // High while board drives sense
   output logic data_sense_bit_o, // Sense pin, our drive value
   output logic data_sense_bit_oe_o, // High while we drive sense
   output logic sda_line_o, // Resolved data line level
   input wire logic [2:0] module_select_straps_i, // Static select straps
   input wire logic wb_cyc_i, // Wishbone cycle
   input wire logic wb_stb_i, // Wishbone strobe
   input wire logic wb_we_i, // Wishbone write
   input wire logic [7:0] wb_adr_i, // Byte address
   input wire logic [3:0] wb_sel_i, // Byte lane selects
   input wire logic [31:0] wb_dat_i, // Write data
   output logic [31:0] wb_dat_o, // Read data
   output logic wb_ack_o // Acknowledge
);
   ee_regs_t q, d;
   logic drv_s, scl_s, dir_s;
   logic [2:0] straps_s;
   logic [7:0] mem_rdata;
   logic mem_we;
   logic [7:0] mem_waddr;
   logic sda, scl_rise, scl_fall, start_c, stop_c;
   logic [7:0] rx_byte;
   logic bus_req;

   function automatic logic [7:0] low3_inc(input logic [7:0] a);
      return {a[7:3], 3'(a[2:0] + 3'h1)};
   endfunction

   // The drive bit, clock, sense direction and straps cross in; the sense value
   // the board drives is never read by this block.
   sync2 #(.W(6)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({data_drive_bit_i, serial_clock_bit_i, data_sense_dir_i,
            module_select_straps_i}),
      .q_o({drv_s, scl_s, dir_s, straps_s})
   );

   byte_store #(.AW(AW), .DW(8)) u_store (
      .clk_i(clk_i),
      .we_i(mem_we),
      .waddr_i(mem_waddr),
      .wdata_i(q.shift),
      .raddr_i(q.cur_addr),
      .rdata_o(mem_rdata)
   );

   // Open-collector line: either party pulling wins
   assign sda = ~drv_s & ~q.pull;
   assign scl_rise = scl_s & ~q.scl_prev;
   assign scl_fall = ~scl_s & q.scl_prev;
   // Framing edges with clock held high, polarity as printed
   assign start_c = scl_s & q.scl_prev & sda & ~q.sda_prev;
   assign stop_c = scl_s & q.scl_prev & ~sda & q.sda_prev;
   assign rx_byte = q.shift;
   assign bus_req = wb_cyc_i & wb_stb_i;

   always_comb begin
      d = q;
      mem_we = 1'b0;
      mem_waddr = q.cur_addr;
      d.scl_prev = scl_s;
      d.sda_prev = sda;
      d.line = sda;
      // Sense pin is released while the board owns it for sending
      d.sense_oe = ~dir_s;
      d.sense_o = sda;
      if (q.busy_cnt != 24'h0) begin
         d.busy_cnt = q.busy_cnt - 24'h1;
      end

      if (stop_c) begin
         d.st = S_IDLE;
         d.pull = 1'b0;
         // Only a write that carried data takes the store offline
         if (q.wrote) begin
            d.busy_cnt = 24'(WRITE_CYC);
         end
         d.wrote = 1'b0;
      end else if (start_c) begin
         d.st = S_CMD;
         d.bitcnt = 4'h0;
         d.pull = 1'b0;
         if (q.wrote) begin
            d.busy_cnt = 24'(WRITE_CYC);
         end
         d.wrote = 1'b0;
      end else begin
         unique case (q.st)
            S_IDLE: begin
            end
            S_CMD, S_ADDR, S_WDATA: begin
               if (scl_rise && q.bitcnt != 4'h8) begin
                  d.shift = {q.shift[6:0], sda};
                  d.bitcnt = q.bitcnt + 4'h1;
               end else if (scl_fall && q.bitcnt == 4'h8) begin
                  d.bitcnt = 4'h0;
                  if (q.st == S_CMD) begin
                     // Busy stores and foreign selects stay silent
                     if (rx_byte[7:4] == `EE_DEV_TYPE &&
                         rx_byte[3:1] == straps_s &&
                         q.ctrl_en && q.busy_cnt == 24'h0) begin
                        d.pull = 1'b1;
                        d.is_read = rx_byte[0];
                        d.st = S_CMD_ACK;
                     end else begin
                        d.st = S_IDLE;
                     end
                  end else if (q.st == S_ADDR) begin
                     d.cur_addr = rx_byte;
                     d.pull = 1'b1;
                     d.st = S_ADDR_ACK;
                  end else begin
                     mem_we = 1'b1;
                     d.cur_addr = low3_inc(q.cur_addr);
                     d.wrote = 1'b1;
                     d.pull = 1'b1;
                     d.st = S_WDATA_ACK;
                  end
               end
            end
            S_CMD_ACK: begin
               if (scl_fall) begin
                  if (q.is_read) begin
                     d.shift = mem_rdata;
                     d.pull = ~mem_rdata[7];
                     d.bitcnt = 4'h1;
                     d.st = S_RDATA;
                  end else begin
                     d.pull = 1'b0;
                     d.st = S_ADDR;
                  end
               end
            end
            S_ADDR_ACK, S_WDATA_ACK: begin
               // Further bytes wrap within the eight-byte group
               if (scl_fall) begin
                  d.pull = 1'b0;
                  d.st = S_WDATA;
               end
            end
            S_RDATA: begin
               // Bits change only after the clock falls
               if (scl_fall) begin
                  if (q.bitcnt != 4'h8) begin
                     d.shift = {q.shift[6:0], 1'b0};
                     d.pull = ~q.shift[6];
                     d.bitcnt = q.bitcnt + 4'h1;
                  end else begin
                     d.pull = 1'b0;
                     d.cur_addr = q.cur_addr + 8'h1;
                     d.st = S_RD_MACK;
                  end
               end
            end
            S_RD_MACK: begin
               // Master ack continues; anything else ends the read
               if (scl_rise) begin
                  d.st = sda ? S_IDLE : S_RD_NEXT;
               end
            end
            S_RD_NEXT: begin
               if (scl_fall) begin
                  d.shift = mem_rdata;
                  d.pull = ~mem_rdata[7];
                  d.bitcnt = 4'h1;
                  d.st = S_RDATA;
               end
            end
         endcase
      end

      // Wishbone slave: one wait cycle, ack dropped the cycle after
      d.wb_ack = bus_req & ~q.wb_ack;
      d.wb_dat = 32'h0;
      if (bus_req && !q.wb_ack) begin
         if (wb_we_i) begin
            if (wb_adr_i == `EE_REG_CTRL && wb_sel_i[0]) begin
               d.ctrl_en = wb_dat_i[`EE_CTRL_EN_BIT];
            end
         end else if (wb_adr_i == `EE_REG_CTRL) begin
            d.wb_dat[`EE_CTRL_EN_BIT] = q.ctrl_en;
         end else if (wb_adr_i == `EE_REG_STATUS) begin
            d.wb_dat[`EE_ST_BUSY_BIT] = (q.busy_cnt != 24'h0);
            d.wb_dat[`EE_ST_ACTIVE_BIT] = (q.st != S_IDLE);
            d.wb_dat[`EE_ST_ADDR_LSB +: 8] = q.cur_addr;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.st <= S_IDLE;
         q.ctrl_en <= `EE_CTRL_RESET;
         q.scl_prev <= 1'b1;
         q.sda_prev <= 1'b1;
         q.line <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign wb_ack_o = q.wb_ack;
   assign wb_dat_o = q.wb_dat;
   assign data_sense_bit_o = q.sense_o;
   assign data_sense_bit_oe_o = q.sense_oe;
   assign sda_line_o = q.line;
endmodule // eeprom_twowire

// ==== eeprom_assertions.sv ====
`timescale 1ns/1ps
module eeprom_assertions (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic data_drive_bit_i, // Drive bit
   input wire logic serial_clock_bit_i, // Serial clock
   input wire logic data_sense_dir_i, // Board owns sense
   input wire logic data_sense_bit_oe_o, // Sense enable
   input wire logic sda_line_o, // Line level
   input wire logic wb_cyc_i, // Cycle
   input wire logic wb_stb_i, // Strobe
   input wire logic [31:0] wb_dat_o, // Read data
   input wire logic wb_ack_o // Acknowledge
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   // Board edge settled, so any move is the store's own
   sequence s_move; !data_drive_bit_i [*5] ##0 $changed(sda_line_o);
   endsequence
   property p_ack_next; s_req |=> wb_ack_o; endproperty
   property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   property p_drive_low; data_drive_bit_i [*4] |-> !sda_line_o; endproperty
   property p_move_low; s_move |-> !$past(serial_clock_bit_i, 2);
   endproperty
   property p_high_still;
      (serial_clock_bit_i && !data_drive_bit_i) [*6] |-> $stable(sda_line_o);
   endproperty
   property p_sense_off; data_sense_dir_i [*4] |-> !data_sense_bit_oe_o;
   endproperty
   property p_sense_on; !data_sense_dir_i [*4] |-> data_sense_bit_oe_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   a_ack_once: assert property (p_ack_once) else $error("ack held");
   a_dat_idle: assert property (p_dat_idle) else $error("stray data");
   a_drive_low: assert property (p_drive_low) else $error("line high");
   a_move_low: assert property (p_move_low) else $error("move");
   a_high_still: assert property (p_high_still) else $error("moved");
   a_sense_off: assert property (p_sense_off) else $error("clash");
   a_sense_on: assert property (p_sense_on) else $error("no sense");
endmodule // eeprom_assertions
bind eeprom_twowire eeprom_assertions chk (.clk_i, .rst_i, .data_drive_bit_i,
   .serial_clock_bit_i, .data_sense_dir_i, .data_sense_bit_oe_o, .sda_line_o,
   .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o);

// ==== twowire_master.sv ====
`timescale 1ns/1ps
module twowire_master (
   output logic scl_o, // Serial clock
   output logic drv_o, // High pulls data low
   input wire logic line_i // Resolved data line
);
   // Half period; a real board stretches it past five microseconds
   int h = 160;
   // Clock high: only at idle or after a stop
   bit up = 1'b1;
   initial begin
      scl_o = 1'b1;
      drv_o = 1'b0;
   end
   task automatic start();
      // After a byte the clock is already low; lower it only once
      if (up) begin
         scl_o <= 1'b0;
      end
      up = 1'b0;
      #40 drv_o <= 1'b1;
      #(h - 40) scl_o <= 1'b1;
      #h drv_o <= 1'b0;
      #h scl_o <= 1'b0;
   endtask
   // Bit 0 is the acknowledge slot, 1 leaves it released
   task automatic tx(input logic [8:0] d, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         #40 drv_o <= !d[i];
         #(h - 40) scl_o <= 1'b1;
         #(h / 2) r[i] = line_i;
         #(h / 2) scl_o <= 1'b0;
      end
   endtask
   // Ends with data held low so the next start can rise
   task automatic stop();
      #40 drv_o <= 1'b0;
      #(h - 40) scl_o <= 1'b1;
      up = 1'b1;
      #h drv_o <= 1'b1;
      #h;
   endtask
endmodule // twowire_master

// ==== testbench.sv ====
`timescale 1ns/1ps
`include "eeprom_consts.svh"
`define CHK(nm, ex, sn) begin checked++; if ((sn) !== (ex)) begin \
   mismatches++; $display("wrong value %s exp %0h got %0h", nm, ex, sn); \
end end
module testbench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic dir = 1'b0, sense = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [2:0] straps = 3'h1;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rd;
   logic [8:0] r;
   wire scl, drv, line, ack, sns, sns_oe;
   wire [31:0] dato;
   int mismatches = 0, checked = 0, base, d, n, cur;
   int mem [256];
   eeprom_twowire #(.WRITE_CYC(400)) uut (.clk_i, .rst_i,
      .data_drive_bit_i(drv), .serial_clock_bit_i(scl),
      .data_sense_bit_i(sense), .data_sense_dir_i(dir),
      .data_sense_bit_o(sns), .data_sense_bit_oe_o(sns_oe), .sda_line_o(line),
      .module_select_straps_i(straps), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(dato), .wb_ack_o(ack));
   twowire_master m (.scl_o(scl), .drv_o(drv), .line_i(line));
   initial forever #20 clk_i = ~clk_i;
   task automatic end_sim();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input int v);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= v;
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = dato;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic cmd(input logic [2:0] s, input logic rw);
      m.start();
      m.tx({`EE_DEV_TYPE, s, rw, 1'b1}, r);
   endtask
   task automatic rrd(input int a, input int cnt);
      cmd(straps, 1'b0);
      m.tx({8'(a), 1'b1}, r);
      cmd(straps, 1'b1);
      `CHK("read cmd", 1'b0, r[0])
      for (int i = 0; i < cnt; i++) begin
         m.tx({8'hFF, i == cnt - 1}, r);
         `CHK("read", mem[(a + i) & 255], r[8:1])
      end
      m.stop();
      cur = (a + cnt) & 255;
   endtask
   initial begin
      #2000000;
      mismatches++;
      end_sim();
   end
   initial begin
      void'($urandom(71));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, `EE_REG_CTRL, 0);
      `CHK("ctrl", 1'b1, rd[0])
      `CHK("sense oe", 1'b1, sns_oe)
      `CHK("sense idle", 1'b1, sns)
      wb(1'b1, 8'h08, -1);
      wb(1'b0, 8'h08, 0);
      `CHK("unmapped", 32'h0, rd)
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_i) straps <= 3'(1 - k);
         cmd(3'(k), 1'b0);
         `CHK("other slot", 1'b1, r[0])
         m.stop();
         m.start();
         m.tx({4'h5, straps, 2'b01}, r);
         `CHK("bad type", 1'b1, r[0])
         m.stop();
         cmd(straps, 1'b0);
         `CHK("own slot", 1'b0, r[0])
         `CHK("sense ack", 1'b0, sns)
         m.tx({8'(k * 16 + 3), 1'b1}, r);
         m.stop();
         wb(1'b0, `EE_REG_STATUS, 0);
         `CHK("status", (k * 16 + 3) << 8, rd[15:0])
      end
      wb(1'b1, `EE_REG_CTRL, 0);
      cmd(straps, 1'b0);
      `CHK("disabled", 1'b1, r[0])
      m.stop();
      wb(1'b1, `EE_REG_CTRL, 1);
      $display("test select done");
      @(posedge clk_i) dir <= 1'b1;
      sense <= 1'($urandom);
      base = $urandom & 32'hF8;
      cmd(straps, 1'b0);
      m.tx({8'(base + 5), 1'b1}, r);
      `CHK("sense off", 1'b0, sns_oe)
      for (int i = 0; i < 8; i++) begin
         d = $urandom & 32'hFF;
         mem[base + ((5 + i) & 7)] = d;
         m.tx({8'(d), 1'b1}, r);
         `CHK("data ack", 1'b0, r[0])
      end
      m.stop();
      @(posedge clk_i) dir <= 1'b0;
      wb(1'b0, `EE_REG_STATUS, 0);
      `CHK("busy", 1'b1, rd[0])
      n = 0;
      do begin
         cmd(straps, 1'b0);
         m.stop();
         n++;
      end while (r[0] && n < 20);
      `CHK("polled", 1'b1, n > 1 && r[0] === 1'b0)
      $display("test burst done");
      rrd(base, 8);
      wb(1'b0, `EE_REG_STATUS, 0);
      `CHK("current", cur, rd[15:8])
      m.h = 400;
      rrd(base + 3, 2);
      $display("test read done");
      end_sim();
   end
endmodule // testbench
